/* File: design/rfl_capture.sv */
// Purpose: apb-controlled cable reflectometry pulse and peak capture
// Assumes: line_sample is an asynchronous six-bit offset-coded converter output
// Notes: one window step is FAST_STEP_CYC clocks; read data is taken in the setup cycle
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module rfl_capture
#(
  parameter int SAMPLE_W = rfl_pkg::SAMPLE_W,
  parameter int TIME_W = rfl_pkg::TIME_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [rfl_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rfl_pkg::DATA_W-1:0] pwdata,
  output logic [rfl_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SAMPLE_W-1:0] line_sample,
  output logic pulse_pos,
  output logic pulse_neg,
  output logic tx_pair_sel,
  output logic rx_pair_sel,
  output logic reflect_mode_enable,
  output logic fast_transmitter_select,
  output logic capture_busy
);
  import rfl_pkg::*;

  logic pready_q;
  logic pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic enable_q;
  logic fast_q;
  logic txpair_q;
  logic rxpair_q;
  logic [WIDTH_W-1:0] width_q;
  logic min_q;
  logic rsvd_q;
  logic [SAMPLE_W-1:0] thr_q;
  logic [TIME_W-1:0] start_q;
  logic [TIME_W-1:0] stop_q;
  rfl_state_t state_q;
  logic [PULSE_CNT_W-1:0] pulse_left_q;
  logic [TIME_W-1:0] time_q;
  logic [$clog2(FAST_STEP_CYC+1)-1:0] presc_q;
  logic alt_q;
  logic neg_now_q;
  logic pulse_pos_q;
  logic pulse_neg_q;
  logic busy_q;
  logic [SAMPLE_W-1:0] s1_q;
  logic [SAMPLE_W-1:0] s2_q;
  logic [SAMPLE_W-1:0] s3_q;
  logic [SAMPLE_W-1:0] samp_q;
  logic [SAMPLE_W-1:0] peak_q;
  logic [TIME_W-1:0] ptime_q;
  logic access;
  logic wr_ctl;
  logic wr_win;
  logic launch;
  logic tick;
  logic in_win;
  logic cap_clear;
  logic win_end;
  logic [SAMPLE_W-1:0] clr_thr;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: no wait state, read data and error decided in setup
  assign access = psel & penable & pready_q;
  assign wr_ctl = access & pwrite & ~pslverr_q & (paddr == ADDR_CONTROL);
  assign wr_win = access & pwrite & ~pslverr_q & (paddr == ADDR_WINDOW);

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == ADDR_CONTROL) || (a == ADDR_WINDOW) || (a == ADDR_PEAK);
  endfunction

  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a);
    read_mux = '0;
    if (a == ADDR_CONTROL)
    begin
      read_mux[CTL_ENABLE_BIT] = enable_q;
      read_mux[CTL_FAST_BIT] = fast_q;
      read_mux[CTL_TXPAIR_BIT] = txpair_q;
      read_mux[CTL_RXPAIR_BIT] = rxpair_q;
      read_mux[CTL_SEND_BIT] = busy_q;
      read_mux[CTL_WIDTH_LSB +: WIDTH_W] = width_q;
      read_mux[CTL_MIN_BIT] = min_q;
      read_mux[CTL_RSVD_BIT] = rsvd_q;
      read_mux[CTL_THR_LSB +: SAMPLE_W] = thr_q;
    end
    else if (a == ADDR_WINDOW)
    begin
      read_mux[WIN_START_LSB +: TIME_W] = start_q;
      read_mux[WIN_STOP_LSB +: TIME_W] = stop_q;
    end
    else if (a == ADDR_PEAK)
    begin
      read_mux[PEAK_VALUE_LSB +: SAMPLE_W] = peak_q;
      read_mux[PEAK_TIME_LSB +: TIME_W] = ptime_q;
    end
  endfunction

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= psel & ~penable;
      if (psel && !penable)
      begin
        pslverr_q <= ~addr_hit(paddr);
        prdata_q <= pwrite ? '0 : read_mux(paddr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and window registers; peak register has no write path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_q <= 1'b0;
      fast_q <= 1'b0;
      txpair_q <= 1'b0;
      rxpair_q <= 1'b0;
      width_q <= WIDTH_RST;
      min_q <= 1'b0;
      rsvd_q <= 1'b0;
      thr_q <= THRESHOLD_RST;
    end
    else if (wr_ctl)
    begin
      enable_q <= pwdata[CTL_ENABLE_BIT];
      fast_q <= pwdata[CTL_FAST_BIT];
      txpair_q <= pwdata[CTL_TXPAIR_BIT];
      rxpair_q <= pwdata[CTL_RXPAIR_BIT];
      width_q <= pwdata[CTL_WIDTH_LSB +: WIDTH_W];
      min_q <= pwdata[CTL_MIN_BIT];
      rsvd_q <= pwdata[CTL_RSVD_BIT];
      thr_q <= pwdata[CTL_THR_LSB +: SAMPLE_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q <= WINDOW_RST;
      stop_q <= WINDOW_RST;
    end
    else if (wr_win)
    begin
      start_q <= pwdata[WIN_START_LSB +: TIME_W];
      stop_q <= pwdata[WIN_STOP_LSB +: TIME_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line sample synchroniser: accept only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= SAMPLE_ZERO;
      s2_q <= SAMPLE_ZERO;
      s3_q <= SAMPLE_ZERO;
      samp_q <= SAMPLE_ZERO;
    end
    else
    begin
      s1_q <= line_sample;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        samp_q <= s3_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture sequencer; a request while busy is dropped, not queued
  assign launch = wr_ctl & pwdata[CTL_SEND_BIT] & (state_q == RFL_IDLE);
  assign tick = (state_q == RFL_RUN) && (presc_q == ($bits(presc_q))'(FAST_STEP_CYC - 1));
  assign win_end = tick && (time_q == stop_q);
  assign in_win = tick && (time_q >= start_q) && (time_q <= stop_q);
  assign cap_clear = launch;
  // the request write also loads a new threshold; seed the peak with that one, not the stale register
  assign clr_thr = launch ? pwdata[CTL_THR_LSB +: SAMPLE_W] : thr_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= RFL_IDLE;
    else
    begin
      case (state_q)
        RFL_IDLE:
          if (launch)
            state_q <= RFL_RUN;
        RFL_RUN:
          if (win_end)
            state_q <= RFL_DRAIN;
        RFL_DRAIN:
          // a pulse longer than the window finishes before the bit clears
          if (pulse_left_q == '0)
            state_q <= RFL_IDLE;
        default:
          state_q <= RFL_IDLE;
      endcase
    end
  end

  // window time base in FAST_STEP_CYC-clock units, one 10 ns clock each
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_q <= '0;
      time_q <= '0;
    end
    else if (launch)
    begin
      presc_q <= '0;
      time_q <= '0;
    end
    else if (state_q == RFL_RUN)
    begin
      if (tick)
      begin
        presc_q <= '0;
        if (!win_end)
          time_q <= time_q + 1'b1;
      end
      else
        presc_q <= presc_q + 1'b1;
    end
  end

  // pulse length and polarity; zero width still runs the window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse_left_q <= '0;
      alt_q <= 1'b0;
      neg_now_q <= 1'b0;
    end
    else if (launch)
    begin
      pulse_left_q <= rfl_pulse_cycles(pwdata[CTL_WIDTH_LSB +: WIDTH_W], pwdata[CTL_FAST_BIT]);
      neg_now_q <= pwdata[CTL_FAST_BIT] & alt_q;
      if (pwdata[CTL_FAST_BIT])
        alt_q <= ~alt_q;
    end
    else if (pulse_left_q != '0)
      pulse_left_q <= pulse_left_q - 1'b1;
  end

  // registered line-side outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse_pos_q <= 1'b0;
      pulse_neg_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      pulse_pos_q <= (pulse_left_q != '0) & ~neg_now_q;
      pulse_neg_q <= (pulse_left_q != '0) & neg_now_q;
      busy_q <= launch | ((state_q != RFL_IDLE) &
                !((state_q == RFL_DRAIN) && (pulse_left_q == '0)));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // peak tracker
  rfl_peak_track #(
    .SW(SAMPLE_W),
    .TW(TIME_W)
  ) u_peak (
    .clk(pclk),
    .rst_n(presetn),
    .clear(cap_clear),
    .threshold(clr_thr),
    .min_mode(min_q),
    .in_window(in_win),
    .sample(samp_q),
    .sample_time(time_q),
    .peak_q(peak_q),
    .time_q(ptime_q)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pulse_pos = pulse_pos_q;
  assign pulse_neg = pulse_neg_q;
  assign tx_pair_sel = txpair_q;
  assign rx_pair_sel = rxpair_q;
  assign reflect_mode_enable = enable_q;
  assign fast_transmitter_select = fast_q;
  assign capture_busy = busy_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [PULSE_CNT_W-1:0] exp_len_q;
  logic [PULSE_CNT_W-1:0] run_len_q;
  logic pulse_any;
  assign pulse_any = pulse_pos_q | pulse_neg_q;

  // helper: expected and measured pulse length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exp_len_q <= '0;
      run_len_q <= '0;
    end
    else
    begin
      if (launch)
        exp_len_q <= rfl_pulse_cycles(pwdata[CTL_WIDTH_LSB +: WIDTH_W], pwdata[CTL_FAST_BIT]);
      run_len_q <= pulse_any ? run_len_q + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  launch_busy_a: assert property (launch |=> busy_q && state_q == RFL_RUN ##1 busy_q)
    else $error("request did not start a capture");
  fast_width_a: assert property ($fell(pulse_any) && fast_q |-> run_len_q == exp_len_q)
    else $error("fast pulse length wrong");
  slow_width_a: assert property ($fell(pulse_any) && !fast_q |->
    (run_len_q == PULSE_CNT_W'(SLOW_STEP_CYC) || run_len_q == PULSE_CNT_W'(2*SLOW_STEP_CYC)))
    else $error("slow pulse not 50 or 100 ns");
  zero_width_a: assert property (launch && pwdata[CTL_WIDTH_LSB +: WIDTH_W] == '0 |=> !pulse_any [*3])
    else $error("pulse sent at zero width");
  thr_side_a: assert property (state_q == RFL_DRAIN && peak_q != thr_q |->
    rfl_beyond(peak_q, thr_q, min_q))
    else $error("peak on wrong side of threshold");
  peak_update_a: assert property (in_win && rfl_beyond(samp_q, peak_q, min_q) && !cap_clear |=>
    peak_q == $past(samp_q) && ptime_q == $past(time_q))
    else $error("peak not captured");
  tie_hold_a: assert property (in_win && samp_q == peak_q |=> $stable(ptime_q))
    else $error("tie moved peak time");
  window_only_a: assert property ($changed(ptime_q) && !$past(cap_clear) |->
    $past(time_q) >= start_q && $past(time_q) <= stop_q)
    else $error("peak taken outside window");
  rsvd_zero_a: assert property (pready_q && paddr == ADDR_PEAK && !pwrite |->
    prdata_q[DATA_W-1:PEAK_VALUE_LSB+SAMPLE_W] == '0)
    else $error("peak reserved bits not zero");
  polarity_alt_a: assert property (launch && pwdata[CTL_FAST_BIT] |=> neg_now_q == $past(alt_q)
    && alt_q != $past(alt_q))
    else $error("fast pulses did not alternate");

  launch_c: cover property (launch ##[1:300] $fell(busy_q));
  min_peak_c: cover property (min_q && in_win && rfl_beyond(samp_q, peak_q, 1'b1));
  neg_pulse_c: cover property ($rose(pulse_neg_q));

endmodule // rfl_capture
`default_nettype wire

/* File: include/rfl_pkg.sv */
// Purpose: constants, types and helpers shared by the reflectometry capture unit
// Assumes: apb slave with 32-bit data, 100 MHz pclk, one line sample per clock
// Notes: register indices are word indices; byte address is four times the index
package rfl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SAMPLE_W = 6;
  localparam int TIME_W = 8;
  localparam int WIDTH_W = 3;

  // printed register indices and derived byte addresses
  localparam logic [ADDR_W-1:0] IDX_CONTROL = 8'h16;
  localparam logic [ADDR_W-1:0] IDX_WINDOW = 8'h17;
  localparam logic [ADDR_W-1:0] IDX_PEAK = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_WINDOW = {IDX_WINDOW[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PEAK = {IDX_PEAK[5:0], 2'b00};

  // control field positions
  localparam int CTL_ENABLE_BIT = 15;
  localparam int CTL_FAST_BIT = 14;
  localparam int CTL_TXPAIR_BIT = 13;
  localparam int CTL_RXPAIR_BIT = 12;
  localparam int CTL_SEND_BIT = 11;
  localparam int CTL_WIDTH_LSB = 8;
  localparam int CTL_MIN_BIT = 7;
  localparam int CTL_RSVD_BIT = 6;
  localparam int CTL_THR_LSB = 0;
  localparam int WIN_START_LSB = 8;
  localparam int WIN_STOP_LSB = 0;
  localparam int PEAK_VALUE_LSB = 8;
  localparam int PEAK_TIME_LSB = 0;

  // reset values
  localparam logic [SAMPLE_W-1:0] THRESHOLD_RST = 6'h20;
  localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 6'h20;
  localparam logic [WIDTH_W-1:0] WIDTH_RST = 3'h0;
  localparam logic [TIME_W-1:0] WINDOW_RST = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FAST_STEP_NS = 8;
  localparam int SLOW_STEP_NS = 50;
  localparam int SLOW_MAX_STEPS = 2;
  localparam int FAST_STEP_CYC = ((FAST_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                 ((FAST_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SLOW_STEP_CYC = ((SLOW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                 ((SLOW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int PULSE_CNT_W = 8;

  typedef enum logic [1:0] {RFL_IDLE, RFL_RUN, RFL_DRAIN} rfl_state_t;

  // true when a beats b in the selected peak direction
  function automatic logic rfl_beyond(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b,
                                      input logic min_mode);
    rfl_beyond = min_mode ? (a < b) : (a > b);
  endfunction

  // pulse length in clocks for a width field and transmitter choice
  function automatic logic [PULSE_CNT_W-1:0] rfl_pulse_cycles(input logic [WIDTH_W-1:0] w,
                                                              input logic fast);
    int unsigned steps;
    steps = 0;
    if (fast)
      steps = w * FAST_STEP_CYC;
    else if (w != '0)
      steps = (w >= SLOW_MAX_STEPS ? SLOW_MAX_STEPS : 1) * SLOW_STEP_CYC;
    rfl_pulse_cycles = PULSE_CNT_W'(steps);
  endfunction

endpackage

/* File: design/rfl_peak_track.sv */
// Purpose: peak value and first-occurrence time tracker
// Assumes: clear arrives before the first windowed sample of a capture
// Notes: starts from the threshold so only beyond-threshold samples register
`timescale 1ns/10ps
`default_nettype none
module rfl_peak_track
  import rfl_pkg::*;
#(
  parameter int SW = rfl_pkg::SAMPLE_W,
  parameter int TW = rfl_pkg::TIME_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic [SW-1:0] threshold,
  input wire logic min_mode,
  input wire logic in_window,
  input wire logic [SW-1:0] sample,
  input wire logic [TW-1:0] sample_time,
  output logic [SW-1:0] peak_q,
  output logic [TW-1:0] time_q
);

  ////////////////////////////////////////////////////////////////////////
  // strict compare keeps the earliest time on ties
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      peak_q <= '0;
      time_q <= '0;
    end
    else if (clear)
    begin
      peak_q <= threshold;
      time_q <= '0;
    end
    else if (in_window && rfl_beyond(sample, peak_q, min_mode))
    begin
      peak_q <= sample;
      time_q <= sample_time;
    end
  end

endmodule // rfl_peak_track
`default_nettype wire

/* File: test/rfl_cable_model.sv */
// Purpose: cable pair seen from the capture unit, echoing each test pulse
// Assumes: one echo of echo_level after echo_delay clocks, flat baseline otherwise
// Notes: line rests at the zero code between echoes, as an idle pair would
`timescale 1ns/10ps
`default_nettype none
module rfl_cable_model
  import rfl_pkg::*;
#(
  parameter int PLATEAU = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pulse_pos,
  input wire logic pulse_neg,
  input wire logic [7:0] echo_delay,
  input wire logic [rfl_pkg::SAMPLE_W-1:0] echo_level,
  output logic [rfl_pkg::SAMPLE_W-1:0] line_sample
);
  logic armed_q;
  logic [7:0] since_q;

  ////////////////////////////////////////////////////////////////
  // echo timer, started by either pulse polarity; re-arm only after the echo is over
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      armed_q <= 1'b0;
      since_q <= 8'h00;
    end
    else if ((pulse_pos || pulse_neg) && !armed_q)
    begin
      armed_q <= 1'b1;
      since_q <= 8'h00;
    end
    else if (armed_q)
    begin
      since_q <= since_q + 8'h01;
      if (since_q == echo_delay + PLATEAU)
        armed_q <= 1'b0;
    end
  end

  // flat plateau long enough to survive the input synchroniser
  assign line_sample = (armed_q && since_q >= echo_delay) ? echo_level : SAMPLE_ZERO;
endmodule // rfl_cable_model
`default_nettype wire

/* File: test/cable_reflectometry_capture_test.sv */
// Purpose: self-checking bench for the reflectometry capture unit
// Assumes: single pclk domain, apb master with setup and access phases
// Notes: echo time is checked to a range because of the input synchroniser
`timescale 1ns/10ps
`default_nettype none
module cable_reflectometry_capture_test;
  import rfl_pkg::*;
  localparam logic [15:0] CORNERS = 16'hf210;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, pulse_pos, pulse_neg;
  logic tx_pair_sel, rx_pair_sel, reflect_mode_enable, fast_transmitter_select, capture_busy;
  logic [7:0] paddr, echo_delay;
  logic [31:0] pwdata, prdata;
  logic [31:0] seed = 32'h0000_004f;
  logic [5:0] line_sample, echo_level;
  int mismatches, compares, pos_cnt, neg_cnt, dpos, dneg;

  always #5 pclk = ~pclk;

  // pulse length meter, differenced around each capture
  always @(posedge pclk)
  begin
    pos_cnt += pulse_pos;
    neg_cnt += pulse_neg;
  end

  rfl_capture i_rfl_capture (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_sample(line_sample), .pulse_pos(pulse_pos), .pulse_neg(pulse_neg),
    .tx_pair_sel(tx_pair_sel), .rx_pair_sel(rx_pair_sel), .reflect_mode_enable(reflect_mode_enable),
    .fast_transmitter_select(fast_transmitter_select), .capture_busy(capture_busy));
  rfl_cable_model i_rfl_cable_model (.pclk(pclk), .presetn(presetn), .pulse_pos(pulse_pos),
    .pulse_neg(pulse_neg), .echo_delay(echo_delay), .echo_level(echo_level), .line_sample(line_sample));

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic beyond(input logic [5:0] a, input logic [5:0] b, input logic m);
    return m ? (a < b) : (a > b);
  endfunction

  // slow pulser only knows 50 ns and 100 ns
  function automatic int plen(input logic [2:0] w, input logic f);
    if (f || w == 3'h0)
      return f ? w : 0;
    return (w == 3'h1 ? 1 : 2) * SLOW_STEP_NS / CLK_PERIOD_NS;
  endfunction

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      mismatches++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////
  // one request, wait for self-clear, then judge pulse and peak
  task automatic capture(input logic [2:0] w, input logic f, input logic m, input logic [5:0] thr,
                         input logic [7:0] st, input logic [7:0] sp, input logic [3:0] pins);
    logic [31:0] rd, ctl;
    logic er;
    logic [5:0] ep;
    logic [7:0] et;
    int p0, n0, n;
    ctl = {16'h0000, pins[3], f, pins[1:0], 1'b1, w, m, 1'b0, thr};
    apb(1'b1, ADDR_WINDOW, {16'h0000, st, sp}, rd, er);
    p0 = pos_cnt;
    n0 = neg_cnt;
    apb(1'b1, ADDR_CONTROL, ctl, rd, er);
    chk("busy after request", 32'h1, capture_busy);
    chk("pin selects", {pins[3], f, pins[1:0]}, {reflect_mode_enable, fast_transmitter_select, tx_pair_sel, rx_pair_sel});
    n = 0;
    do
    begin
      apb(1'b0, ADDR_CONTROL, 32'h0, rd, er);
      n++;
    end
    while (rd[CTL_SEND_BIT] !== 1'b0 && n < 200);
    if (n >= 200)
    begin
      mismatches++;
      complete_run();
    end
    chk("control readback", ctl & ~32'h0000_0800, rd);
    chk("busy after done", 32'h0, capture_busy);
    dpos = pos_cnt - p0;
    dneg = neg_cnt - n0;
    chk("pulse length", plen(w, f), dpos + dneg);
    if (!f)
      chk("slow pulse negative", 32'h0, dneg);
    ep = thr;
    et = 8'h00;
    if (beyond(SAMPLE_ZERO, ep, m))
    begin
      ep = SAMPLE_ZERO;
      et = st;
    end
    apb(1'b0, ADDR_PEAK, 32'h0, rd, er);
    chk("peak upper bits", 32'h0, rd[31:14]);
    if (sp > 8'h06 && w != 3'h0 && beyond(echo_level, ep, m))
    begin
      chk("echo peak value", echo_level, rd[13:8]);
      chk("echo peak time", 32'h1, 32'(rd[7:0] > echo_delay && rd[7:0] <= echo_delay + 8'h07));
    end
    else
    begin
      chk("baseline peak value", ep, rd[13:8]);
      chk("baseline peak time", et, rd[7:0]);
    end
    // a short window ends before its echo; let the echo and the model's arming die out first
    repeat (48) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    complete_run();
  end

  initial
  begin
    logic [31:0] rd, r;
    logic er;
    logic [2:0] w;
    logic f;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    echo_delay = 8'h0c;
    echo_level = 6'h30;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CONTROL, 32'h0, rd, er);
    chk("control reset", 32'h0000_0020, rd);
    apb(1'b0, ADDR_WINDOW, 32'h0, rd, er);
    chk("window reset", 32'h0, rd);
    apb(1'b1, ADDR_PEAK, 32'hffff_ffff, rd, er);
    apb(1'b0, ADDR_PEAK, 32'h0, rd, er);
    chk("peak after write", 32'h0, rd);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk("unmapped error", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    $display("test registers done");
    // fast pulses alternate, first one positive
    capture(3'h3, 1'b1, 1'b0, 6'h3f, 8'h00, 8'h28, 4'hc);
    chk("first fast pulse", 32'h3, dpos);
    capture(3'h3, 1'b1, 1'b0, 6'h3f, 8'h00, 8'h28, 4'hf);
    chk("second fast pulse", 32'h3, dneg);
    $display("test polarity done");
    for (int i = 0; i < 24; i++)
    begin
      r = rnd();
      w = r[2:0];
      f = r[3];
      if (i < 4)
        {f, w} = CORNERS[i*4 +: 4];
      echo_delay <= 8'h0c + 8'(r[17:14]);
      echo_level <= r[23:18];
      capture(w, f, r[4], r[10:5], 8'(r[12:11]),
              r[13] ? 8'h1a + 8'(r[17:14]) + 8'(r[29:24]) : 8'(r[12:11]) + 8'(r[31:30]), 4'(rnd()));
    end
    $display("test random captures done");
    complete_run();
  end
endmodule // cable_reflectometry_capture_test
`default_nettype wire
